// *** pkg/tmb_pkg.sv ***
// Constants and carriers for the terminal memory command block.
// Assumes a parser upstream that decodes text commands into tmb_cmd_s.
package tmb_pkg;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TERM = 3;
  localparam logic [1:0] TERM_MAX = 2'h2;
  localparam int unsigned NUM_Q = 16;
  localparam logic [15:0] Q_CAP_MAX = 16'h7fff;
  localparam logic [15:0] PERS_BYTES_MAX = 16'h2710; // 10,000
  localparam logic [15:0] RXP_BYTES_MAX = 16'h1f40; // 8000
  localparam logic [15:0] SHM_WORDS_MAX = 16'hffff;
  localparam int unsigned SHM_AW = 10;
  localparam int unsigned PERS_AW = 10;
  localparam int unsigned TEST_SEG_AW = 2;
  localparam int unsigned TEST_OFS_AW = 8;
  localparam int unsigned Q_AW = 8;
  localparam logic [1:0] TERM_RST = 2'h0;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TMB_OP_NONE,
    TMB_OP_SHM_WR,
    TMB_OP_MULTI_WR,
    TMB_OP_RX_WR,
    TMB_OP_TEST_WR,
    TMB_OP_TX_WR,
    TMB_OP_CLR_Q,
    TMB_OP_CLR_ALL_Q,
    TMB_OP_CLR_FIFO,
    TMB_OP_DEF_Q,
    TMB_OP_Q_WR
  } tmb_op_e;

  // Decoded command as handed over by the text parser
  typedef struct packed {
    tmb_op_e op;
    logic term_given;
    logic [1:0] term;
    logic all_sfx;
    logic [3:0] q_idx;
    logic [1:0] seg;
    logic [15:0] start;
    logic [15:0] count;
    logic [15:0] cell_sz;
    logic [15:0] cells;
  } tmb_cmd_s;

  // Shared memory write toward a terminal
  typedef struct packed {
    logic vld;
    logic [1:0] term;
    logic [SHM_AW-1:0] addr;
    logic [15:0] data;
  } tmb_shm_wr_s;

  // Byte write into a personality or test memory
  typedef struct packed {
    logic vld;
    logic [1:0] term;
    logic [1:0] mem; // 0 multi, 1 rx, 2 tx, 3 test
    logic [15:0] addr;
    logic [7:0] data;
  } tmb_byte_wr_s;

  localparam logic [1:0] MEM_MULTI = 2'h0;
  localparam logic [1:0] MEM_RX = 2'h1;
  localparam logic [1:0] MEM_TX = 2'h2;
  localparam logic [1:0] MEM_TEST = 2'h3;

endpackage

// *** core/tmb_queue.sv ***
// One circular word queue of the queue bank.
// Assumes definition and clear are single-cycle pulses from the command core.
`timescale 1ns/10ps
module tmb_queue (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic def_i,
  input wire logic [15:0] cell_sz_i,
  input wire logic [15:0] cells_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  output logic cell_rdy_o,
  output logic [15:0] cell_sz_o
);
  localparam int unsigned Q_AW_L = tmb_pkg::Q_AW;
  logic [15:0] mem [0:(1<<tmb_pkg::Q_AW)-1];
  logic [Q_AW_L-1:0] wp_ff, rp_ff;
  logic rd_data_last_c;
  logic [15:0] rd_cnt_ff;
  logic [15:0] cap_ff, used_ff, fill_ff, cell_sz_ff;
  logic [15:0] cells_done_ff;
  logic [Q_AW_L-1:0] nxt_wp, nxt_rp;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  // Definition only, clears keep geometry
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cell_sz_ff <= 16'h0000;
      cap_ff <= 16'h0000;
    end else if (def_i) begin
      cell_sz_ff <= cell_sz_i;
      cap_ff <= 16'(cell_sz_i * cells_i);
    end
  end

  assign nxt_wp = (wp_ff == Q_AW_L'(cap_ff - 16'h0001)) ? '0 : wp_ff + 1'b1;
  assign nxt_rp = (rp_ff == Q_AW_L'(cap_ff - 16'h0001)) ? '0 : rp_ff + 1'b1;

  // ----------------------------------------------------------------
  // Pointers and occupancy
  // ----------------------------------------------------------------
  // Writes go in at one end, reads leave at the other
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || clr_i || def_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      used_ff <= 16'h0000;
      fill_ff <= 16'h0000;
      cells_done_ff <= 16'h0000;
    end else begin
      if (wr_i && used_ff < cap_ff) begin
        wp_ff <= nxt_wp;
        fill_ff <= (fill_ff + 16'h0001 == cell_sz_ff) ? 16'h0000 : fill_ff + 16'h0001;
      end
      if (rd_i && used_ff != 16'h0000) begin
        rp_ff <= nxt_rp;
      end
      used_ff <= used_ff + 16'(wr_i && used_ff < cap_ff) - 16'(rd_i && used_ff != 16'h0000);
      // Cell counted only when its last word lands
      if (wr_i && used_ff < cap_ff && fill_ff + 16'h0001 == cell_sz_ff) begin
        cells_done_ff <= cells_done_ff + 16'h0001;
      end else if (rd_i && rd_data_last_c) begin
        cells_done_ff <= cells_done_ff - 16'h0001;
      end
    end
  end

  // Last word of the cell being read out
  assign rd_data_last_c = (rd_cnt_ff + 16'h0001 == cell_sz_ff);

  // Words read out of the current cell
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || clr_i || def_i) begin
      rd_cnt_ff <= 16'h0000;
    end else if (rd_i && used_ff != 16'h0000) begin
      rd_cnt_ff <= rd_data_last_c ? 16'h0000 : rd_cnt_ff + 16'h0001;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (wr_i && used_ff < cap_ff) begin
      mem[wp_ff] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rp_ff];
  assign cell_rdy_o = (cells_done_ff != 16'h0000);
  assign cell_sz_o = cell_sz_ff;

endmodule // tmb_queue

// *** core/tmb_cmd_core.sv ***
// Command executor: bulk memory writes, queue set-up and clears.
// Assumes decoded commands and payload bytes synchronous to clk_sys_i.
`timescale 1ns/10ps
module tmb_cmd_core (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire tmb_pkg::tmb_cmd_s cmd_i,
  input wire logic cmd_vld_i,
  output logic cmd_rdy_o,
  input wire logic [7:0] byte_i,
  input wire logic byte_vld_i,
  input wire logic [2:0] term_dis_i,
  input wire logic [2:0] term_test_i,
  input wire logic [2:0] xmit_done_i,
  input wire logic [2:0] link_en_i,
  input wire logic [3:0] link_q_i [0:2],
  output tmb_pkg::tmb_shm_wr_s shm_wr_o,
  output tmb_pkg::tmb_byte_wr_s byte_wr_o,
  output logic [2:0] fifo_clr_o,
  output logic cmd_rej_o,
  output logic [1:0] cur_term_o
);
  typedef enum logic [2:0] {
    TMB_ST_IDLE,
    TMB_ST_BYTES,
    TMB_ST_WORDS,
    TMB_ST_QWORDS,
    TMB_ST_MOVE
  } tmb_state_e;

  tmb_state_e st_ff;
  tmb_pkg::tmb_cmd_s cmd_ff;
  logic [1:0] term_ff, eff_term;
  logic [15:0] left_ff, addr_ff;
  logic lo_have_ff;
  logic [7:0] lo_ff;
  logic ok;
  logic [15:0] cap;
  logic [tmb_pkg::NUM_Q-1:0] q_def, q_clr, q_wr, q_rd, q_rdy;
  logic [15:0] q_data [0:tmb_pkg::NUM_Q-1];
  logic [15:0] q_csz [0:tmb_pkg::NUM_Q-1];
  logic [1:0] mv_term_ff;
  logic [3:0] mv_q_ff;
  logic [15:0] wd;

  // ----------------------------------------------------------------
  // Command check
  // ----------------------------------------------------------------
  assign eff_term = cmd_i.term_given ? cmd_i.term : term_ff;
  assign cap = 16'(cmd_i.cell_sz * cmd_i.cells);

  // Decide acceptance before touching any memory
  always_comb begin
    ok = !(cmd_i.term_given && cmd_i.term > tmb_pkg::TERM_MAX);
    case (cmd_i.op)
      tmb_pkg::TMB_OP_MULTI_WR, tmb_pkg::TMB_OP_TX_WR: begin
        ok = ok && term_dis_i[eff_term] && cmd_i.count != 16'h0000
          && cmd_i.count <= tmb_pkg::PERS_BYTES_MAX;
      end
      tmb_pkg::TMB_OP_RX_WR: begin
        ok = ok && term_dis_i[eff_term] && cmd_i.count != 16'h0000
          && cmd_i.count <= tmb_pkg::RXP_BYTES_MAX;
      end
      tmb_pkg::TMB_OP_TEST_WR: begin
        ok = ok && term_dis_i[eff_term] && term_test_i[eff_term];
      end
      tmb_pkg::TMB_OP_SHM_WR: ok = ok;
      tmb_pkg::TMB_OP_DEF_Q: begin
        ok = ok && cap <= tmb_pkg::Q_CAP_MAX
          && 32'(cmd_i.cell_sz) * 32'(cmd_i.cells) <= 32'(tmb_pkg::Q_CAP_MAX)
          && cap <= 16'(1 << tmb_pkg::Q_AW) && cmd_i.cell_sz != 16'h0000;
      end
      tmb_pkg::TMB_OP_CLR_Q, tmb_pkg::TMB_OP_CLR_ALL_Q, tmb_pkg::TMB_OP_CLR_FIFO,
      tmb_pkg::TMB_OP_Q_WR: ok = ok;
      default: ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Bulk transfers hold the core until every byte is taken
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_ff <= TMB_ST_IDLE;
      cmd_ff <= '0;
      left_ff <= 16'h0000;
      addr_ff <= 16'h0000;
      lo_have_ff <= 1'b0;
      lo_ff <= 8'h00;
      mv_term_ff <= 2'h0;
      mv_q_ff <= 4'h0;
    end else begin
      case (st_ff)
        TMB_ST_IDLE: begin
          if (cmd_vld_i && ok) begin
            cmd_ff <= cmd_i;
            cmd_ff.term <= eff_term;
            left_ff <= cmd_i.count;
            lo_have_ff <= 1'b0;
            // Test memory offset sits inside the chosen segment
            addr_ff <= (cmd_i.op == tmb_pkg::TMB_OP_TEST_WR) ?
              {6'h00, cmd_i.seg, cmd_i.start[7:0]} : cmd_i.start;
            case (cmd_i.op)
              tmb_pkg::TMB_OP_MULTI_WR, tmb_pkg::TMB_OP_RX_WR, tmb_pkg::TMB_OP_TX_WR,
              tmb_pkg::TMB_OP_TEST_WR: st_ff <= TMB_ST_BYTES;
              tmb_pkg::TMB_OP_SHM_WR: st_ff <= TMB_ST_WORDS;
              tmb_pkg::TMB_OP_Q_WR: st_ff <= TMB_ST_QWORDS;
              default: st_ff <= TMB_ST_IDLE;
            endcase
          end else if (!cmd_vld_i) begin
            // Check linked queues after a wordstring sent while idle with no command; highest terminal wins
            for (int t = 0; t < 3; t++) begin
              if (xmit_done_i[t] && link_en_i[t] && q_rdy[link_q_i[t]]) begin
                mv_term_ff <= 2'(t);
                mv_q_ff <= link_q_i[t];
                left_ff <= q_csz[link_q_i[t]];
                addr_ff <= 16'h0000;
                st_ff <= TMB_ST_MOVE;
              end
            end
          end
        end
        TMB_ST_BYTES: begin
          if (byte_vld_i) begin
            addr_ff <= addr_ff + 16'h0001;
            left_ff <= left_ff - 16'h0001;
            if (left_ff == 16'h0001) st_ff <= TMB_ST_IDLE;
          end
        end
        TMB_ST_WORDS, TMB_ST_QWORDS: begin
          if (byte_vld_i) begin
            lo_have_ff <= !lo_have_ff;
            lo_ff <= byte_i;
            if (lo_have_ff) begin
              addr_ff <= addr_ff + 16'h0001;
              left_ff <= left_ff - 16'h0001;
              if (left_ff == 16'h0001) st_ff <= TMB_ST_IDLE;
            end
          end
        end
        TMB_ST_MOVE: begin
          addr_ff <= addr_ff + 16'h0001;
          left_ff <= left_ff - 16'h0001;
          if (left_ff == 16'h0001) st_ff <= TMB_ST_IDLE;
        end
        default: st_ff <= TMB_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Selected terminal
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      term_ff <= tmb_pkg::TERM_RST;
    end else if (st_ff == TMB_ST_IDLE && cmd_vld_i && ok && cmd_i.term_given) begin
      term_ff <= cmd_i.term;
    end
  end

  // ----------------------------------------------------------------
  // Queue bank, shared by all terminals
  // ----------------------------------------------------------------
  assign wd = {byte_i, lo_ff};

  genvar gq;
  generate
    for (gq = 0; gq < tmb_pkg::NUM_Q; gq++) begin : g_q
      assign q_def[gq] = st_ff == TMB_ST_IDLE && cmd_vld_i && ok
        && cmd_i.op == tmb_pkg::TMB_OP_DEF_Q && cmd_i.q_idx == 4'(gq);
      assign q_clr[gq] = st_ff == TMB_ST_IDLE && cmd_vld_i && ok
        && ((cmd_i.op == tmb_pkg::TMB_OP_CLR_Q && cmd_i.q_idx == 4'(gq))
        || cmd_i.op == tmb_pkg::TMB_OP_CLR_ALL_Q);
      assign q_wr[gq] = st_ff == TMB_ST_QWORDS && byte_vld_i && lo_have_ff
        && cmd_ff.q_idx == 4'(gq);
      assign q_rd[gq] = st_ff == TMB_ST_MOVE && mv_q_ff == 4'(gq);
      tmb_queue u_q (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .def_i(q_def[gq]),
        .cell_sz_i(cmd_i.cell_sz),
        .cells_i(cmd_i.cells),
        .clr_i(q_clr[gq]),
        .wr_i(q_wr[gq]),
        .wr_data_i(wd),
        .rd_i(q_rd[gq]),
        .rd_data_o(q_data[gq]),
        .cell_rdy_o(q_rdy[gq]),
        .cell_sz_o(q_csz[gq])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Memory write ports, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      shm_wr_o <= '0;
    end else if (st_ff == TMB_ST_WORDS && byte_vld_i && lo_have_ff) begin
      shm_wr_o <= '{1'b1, cmd_ff.term, addr_ff[tmb_pkg::SHM_AW-1:0], wd};
    end else if (st_ff == TMB_ST_MOVE) begin
      shm_wr_o <= '{1'b1, mv_term_ff, addr_ff[tmb_pkg::SHM_AW-1:0], q_data[mv_q_ff]};
    end else begin
      shm_wr_o <= '0;
    end
  end

  // Byte memories, one byte per payload character
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      byte_wr_o <= '0;
    end else if (st_ff == TMB_ST_BYTES && byte_vld_i) begin
      byte_wr_o.vld <= 1'b1;
      byte_wr_o.term <= cmd_ff.term;
      byte_wr_o.addr <= addr_ff;
      byte_wr_o.data <= byte_i;
      case (cmd_ff.op)
        tmb_pkg::TMB_OP_MULTI_WR: byte_wr_o.mem <= tmb_pkg::MEM_MULTI;
        tmb_pkg::TMB_OP_RX_WR: byte_wr_o.mem <= tmb_pkg::MEM_RX;
        tmb_pkg::TMB_OP_TX_WR: byte_wr_o.mem <= tmb_pkg::MEM_TX;
        default: byte_wr_o.mem <= tmb_pkg::MEM_TEST;
      endcase
    end else begin
      byte_wr_o <= '0;
    end
  end

  // Vector FIFO clears and rejection pulse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fifo_clr_o <= 3'h0;
      cmd_rej_o <= 1'b0;
    end else begin
      fifo_clr_o <= 3'h0;
      cmd_rej_o <= st_ff == TMB_ST_IDLE && cmd_vld_i && !ok;
      if (st_ff == TMB_ST_IDLE && cmd_vld_i && ok && cmd_i.op == tmb_pkg::TMB_OP_CLR_FIFO) begin
        fifo_clr_o <= cmd_i.all_sfx ? 3'h7 : 3'(3'h1 << eff_term);
      end
    end
  end

  // Ready a cycle after idle with no take, so also in the first move cycle; registered for a clean output
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cmd_rdy_o <= 1'b0;
      cur_term_o <= tmb_pkg::TERM_RST;
    end else begin
      cmd_rdy_o <= st_ff == TMB_ST_IDLE && !(cmd_vld_i && cmd_rdy_o);
      cur_term_o <= term_ff;
    end
  end

endmodule // tmb_cmd_core

// *** bench/tmb_cmd_core_assertions.sv ***
// Checker for the command core, watching its top ports only.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
module tmb_cmd_core_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire tmb_pkg::tmb_cmd_s cmd_i,
  input wire logic cmd_vld_i,
  input wire logic cmd_rdy_o,
  input wire logic [7:0] byte_i,
  input wire logic byte_vld_i,
  input wire logic [2:0] term_dis_i,
  input wire logic [2:0] term_test_i,
  input wire tmb_pkg::tmb_shm_wr_s shm_wr_o,
  input wire tmb_pkg::tmb_byte_wr_s byte_wr_o,
  input wire logic [2:0] fifo_clr_o,
  input wire logic cmd_rej_o,
  input wire logic [1:0] cur_term_o
);
  // ------------------------------
  // Helper logic and properties
  // ------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic take;
  logic fifo_op;
  logic term_ok;
  logic [7:0] b1_ff;
  logic [7:0] b0_ff;
  assign take = cmd_vld_i & cmd_rdy_o;
  assign fifo_op = take && (cmd_i.op == tmb_pkg::TMB_OP_CLR_FIFO);
  assign term_ok = !(cmd_i.term_given && (cmd_i.term > tmb_pkg::TERM_MAX));

  // Last two payload bytes, so a word can be rebuilt low byte first
  always_ff @(posedge clk_sys_i) begin
    if (byte_vld_i) begin
      b1_ff <= byte_i;
      b0_ff <= b1_ff;
    end
  end

  property p_bad_term; take && !term_ok |=> cmd_rej_o; endproperty
  a_bad_term: assert property (p_bad_term)
    else $error("bad terminal index not refused");
  property p_fifo_one;
    fifo_op && cmd_i.term_given && term_ok && !cmd_i.all_sfx
      |=> fifo_clr_o == (3'h1 << $past(cmd_i.term));
  endproperty
  a_fifo_one: assert property (p_fifo_one)
    else $error("fifo clear missed the named terminal");
  property p_fifo_omit;
    fifo_op && !cmd_i.term_given && !cmd_i.all_sfx |=> fifo_clr_o == (3'h1 << $past(cur_term_o));
  endproperty
  a_fifo_omit: assert property (p_fifo_omit)
    else $error("omitted selector did not reuse current terminal");
  property p_fifo_all; fifo_op && cmd_i.all_sfx && term_ok |=> fifo_clr_o == 3'h7; endproperty
  a_fifo_all: assert property (p_fifo_all)
    else $error("all suffix did not clear every fifo");
  property p_term_keep;
    !$past(take && cmd_i.term_given && term_ok) |=> $stable(cur_term_o);
  endproperty
  a_term_keep: assert property (p_term_keep)
    else $error("current terminal changed without a selector");
  property p_pers_dis;
    byte_wr_o.vld && (byte_wr_o.mem != tmb_pkg::MEM_TEST) |-> term_dis_i[byte_wr_o.term];
  endproperty
  a_pers_dis: assert property (p_pers_dis)
    else $error("personality written while terminal enabled");
  property p_test_ok;
    byte_wr_o.vld && (byte_wr_o.mem == tmb_pkg::MEM_TEST)
      |-> term_dis_i[byte_wr_o.term] && term_test_i[byte_wr_o.term];
  endproperty
  a_test_ok: assert property (p_test_ok)
    else $error("test memory written outside test mode");
  property p_shm_lohi; shm_wr_o.vld && $past(byte_vld_i) |-> shm_wr_o.data == {b1_ff, b0_ff}; endproperty
  a_shm_lohi: assert property (p_shm_lohi)
    else $error("shared word not assembled low byte first");
  property p_byte_data; byte_wr_o.vld |-> byte_wr_o.data == b1_ff; endproperty
  a_byte_data: assert property (p_byte_data)
    else $error("byte write data differs from payload");
  property p_rej_quiet;
    cmd_rej_o |-> (!shm_wr_o.vld && !byte_wr_o.vld && fifo_clr_o == 3'h0)[*3];
  endproperty
  a_rej_quiet: assert property (p_rej_quiet)
    else $error("refused command still wrote");
endmodule // tmb_cmd_core_assertions

bind tmb_cmd_core tmb_cmd_core_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .cmd_i(cmd_i), .cmd_vld_i(cmd_vld_i), .cmd_rdy_o(cmd_rdy_o), .byte_i(byte_i),
  .byte_vld_i(byte_vld_i), .term_dis_i(term_dis_i), .term_test_i(term_test_i),
  .shm_wr_o(shm_wr_o), .byte_wr_o(byte_wr_o), .fifo_clr_o(fifo_clr_o),
  .cmd_rej_o(cmd_rej_o), .cur_term_o(cur_term_o));

// *** bench/tmb_host_model.sv ***
// Host model: issues decoded commands and payload bytes.
// Assumes its tasks are called just after a rising edge.
`timescale 1ns/10ps
module tmb_host_model (
  input wire logic clk_sys_i,
  input wire logic cmd_rdy_i,
  output tmb_pkg::tmb_cmd_s cmd_o,
  output logic cmd_vld_o,
  output logic [7:0] byte_o,
  output logic byte_vld_o
);
  // ----------
  // Drivers
  // ----------
  // Idle lines never keep the last value, so stale data cannot pass
  initial begin
    cmd_o = '0;
    cmd_vld_o = 1'b0;
    byte_o = 8'h5a;
    byte_vld_o = 1'b0;
  end

  // Command held until the edge that samples ready high
  task automatic issue(input tmb_pkg::tmb_cmd_s c);
    @(posedge clk_sys_i);
    cmd_o <= c;
    cmd_vld_o <= 1'b1;
    do @(negedge clk_sys_i); while (cmd_rdy_i !== 1'b1);
    @(posedge clk_sys_i);
    cmd_vld_o <= 1'b0;
    cmd_o <= ~c;
  endtask

  // One byte; a gap paces the host slowly, none back to back
  task automatic put(input logic [7:0] b, input int gap);
    byte_o <= b;
    byte_vld_o <= 1'b1;
    @(posedge clk_sys_i);
    if (gap > 0) begin
      byte_vld_o <= 1'b0;
      byte_o <= ~b;
      repeat (gap) @(posedge clk_sys_i);
    end
  endtask
endmodule // tmb_host_model

// *** bench/tb_top.sv ***
// Self-checking bench for the command core with a scoreboard queue.
// Assumes the host model drives commands and payload bytes.
`timescale 1ns/10ps
module tb_top;
  // -----------------
  // Signals and parts
  // -----------------
  logic clk_sys_i = 1'b0;
  logic rst_b_i;
  tmb_pkg::tmb_cmd_s cmd_i;
  tmb_pkg::tmb_cmd_s c;
  logic cmd_vld_i, cmd_rdy_o, byte_vld_i, cmd_rej_o;
  logic [7:0] byte_i, b;
  logic [2:0] term_dis_i, term_test_i, xmit_done_i, link_en_i, fifo_clr_o;
  logic [3:0] link_q_i [0:2];
  tmb_pkg::tmb_shm_wr_s shm_wr_o;
  tmb_pkg::tmb_byte_wr_s byte_wr_o;
  logic [1:0] cur_term_o;
  logic [15:0] w, st, a;
  logic [15:0] wq [$];
  logic [33:0] exp_q [$];
  int failures = 0;
  int tests_run = 0;
  int seed, n;
  int cyc = 0;
  tmb_pkg::tmb_op_e ops [4] = '{tmb_pkg::TMB_OP_MULTI_WR, tmb_pkg::TMB_OP_RX_WR,
    tmb_pkg::TMB_OP_TX_WR, tmb_pkg::TMB_OP_TEST_WR};
  tmb_pkg::tmb_op_e rops [5] = '{tmb_pkg::TMB_OP_MULTI_WR, tmb_pkg::TMB_OP_RX_WR,
    tmb_pkg::TMB_OP_TX_WR, tmb_pkg::TMB_OP_MULTI_WR, tmb_pkg::TMB_OP_TEST_WR};
  logic [15:0] rcnt [5] = '{16'h2711, 16'h1f41, 16'h0000, 16'h0004, 16'h0004};

  always #12.5 clk_sys_i = ~clk_sys_i;

  tmb_host_model u_host (.clk_sys_i(clk_sys_i), .cmd_rdy_i(cmd_rdy_o), .cmd_o(cmd_i),
    .cmd_vld_o(cmd_vld_i), .byte_o(byte_i), .byte_vld_o(byte_vld_i));
  tmb_cmd_core DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cmd_i(cmd_i),
    .cmd_vld_i(cmd_vld_i), .cmd_rdy_o(cmd_rdy_o), .byte_i(byte_i), .byte_vld_i(byte_vld_i),
    .term_dis_i(term_dis_i), .term_test_i(term_test_i), .xmit_done_i(xmit_done_i),
    .link_en_i(link_en_i), .link_q_i(link_q_i), .shm_wr_o(shm_wr_o), .byte_wr_o(byte_wr_o),
    .fifo_clr_o(fifo_clr_o), .cmd_rej_o(cmd_rej_o), .cur_term_o(cur_term_o));

  // -----------------
  // Tasks
  // -----------------
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (e !== g) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // An output with no note pending compares against all ones
  task automatic take(input string nm, input logic [33:0] g);
    logic [33:0] e;
    e = '1;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    chk(nm, e, g);
  endtask
  task automatic ex(input logic [1:0] k, input logic [31:0] v);
    exp_q.push_back({k, v});
  endtask
  function automatic tmb_pkg::tmb_cmd_s mk(input tmb_pkg::tmb_op_e op, input logic tg,
    input logic [1:0] t, input logic [15:0] s, input logic [15:0] cnt);
    mk = '0;
    mk.op = op;
    mk.term_given = tg;
    mk.term = t;
    mk.start = s;
    mk.count = cnt;
  endfunction
  task automatic wr16(input logic [15:0] v, input bit last, input int slow);
    u_host.put(v[7:0], slow);
    u_host.put(v[15:8], last ? 1 : slow);
  endtask
  task automatic qwr(input int k);
    c = mk(tmb_pkg::TMB_OP_Q_WR, 1'b0, 2'h0, 16'h0, 16'(k));
    c.q_idx = 4'h2;
    u_host.issue(c);
    for (int i = 0; i < k; i++) begin
      w = 16'($random(seed));
      wq.push_back(w);
      wr16(w, i == k - 1, 0);
    end
  endtask
  task automatic xmit();
    @(posedge clk_sys_i) xmit_done_i <= 3'h1;
    @(posedge clk_sys_i) xmit_done_i <= 3'h0;
  endtask
  // Bounded wait for notes, then a quiet spell catches stray outputs
  task automatic fin(input string nm);
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk_sys_i);
    repeat (8) @(posedge clk_sys_i);
    chk("pending", 34'h0, 34'(exp_q.size()));
    exp_q.delete();
    $display("test %s done", nm);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Output watcher, sampled where registered outputs are settled
  always @(negedge clk_sys_i) begin
    if (rst_b_i === 1'b1) begin
      if (shm_wr_o.vld === 1'b1) take("shm_write", {2'h0, 4'h0, shm_wr_o.term, shm_wr_o.addr,
        shm_wr_o.data});
      if (byte_wr_o.vld === 1'b1) take("byte_write", {2'h1, 4'h0, byte_wr_o.term, byte_wr_o.mem,
        byte_wr_o.addr, byte_wr_o.data});
      if (fifo_clr_o !== 3'h0) take("fifo_clear", {2'h2, 29'h0, fifo_clr_o});
      if (cmd_rej_o === 1'b1) take("refusal", {2'h3, 32'h1});
    end
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("MISMATCH timeout exp done got hang");
      wrap_up();
    end
  end

  // -----------------
  // Main sequence
  // -----------------
  initial begin
    seed = 16795;
    rst_b_i = 1'b0;
    xmit_done_i = 3'h0;
    link_en_i = 3'h0;
    link_q_i = '{4'h0, 4'h0, 4'h0};
    term_dis_i = 3'h7;
    term_test_i = 3'h7;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    // Select terminal 1, then a shared write that omits the selector
    ex(2'h2, 32'h2);
    u_host.issue(mk(tmb_pkg::TMB_OP_CLR_FIFO, 1'b1, 2'h1, 16'h0, 16'h0));
    st = 16'($random(seed)) & 16'h01f0;
    n = 2 + ($random(seed) & 3);
    u_host.issue(mk(tmb_pkg::TMB_OP_SHM_WR, 1'b0, 2'h0, st, 16'(n)));
    for (int i = 0; i < n; i++) begin
      w = 16'($random(seed));
      ex(2'h0, {4'h0, 2'h1, 10'(st + i), w});
      wr16(w, i == n - 1, i % 2);
    end
    fin("shared_write");
    // All suffix, omitted selector, then an illegal terminal
    c = mk(tmb_pkg::TMB_OP_CLR_FIFO, 1'b1, 2'h2, 16'h0, 16'h0);
    c.all_sfx = 1'b1;
    ex(2'h2, 32'h7);
    u_host.issue(c);
    ex(2'h2, 32'h4);
    u_host.issue(mk(tmb_pkg::TMB_OP_CLR_FIFO, 1'b0, 2'h0, 16'h0, 16'h0));
    ex(2'h3, 32'h1);
    u_host.issue(mk(tmb_pkg::TMB_OP_CLR_FIFO, 1'b1, 2'h3, 16'h0, 16'h0));
    fin("fifo_clear");
    chk("cur_term", 34'h2, {32'h0, cur_term_o});
    // Every byte memory, test memory through segment 2
    for (int m = 0; m < 4; m++) begin
      st = 16'($random(seed)) & 16'h00f0;
      c = mk(ops[m], 1'b1, (m == 3) ? 2'h0 : 2'(m), st, 16'h4);
      c.seg = 2'h2;
      u_host.issue(c);
      for (int i = 0; i < 4; i++) begin
        b = 8'($random(seed));
        a = (m == 3) ? {6'h0, 2'h2, 8'(st + i)} : st + 16'(i);
        ex(2'h1, {4'h0, c.term, 2'(m), a, b});
        u_host.put(b, (i == 3) ? 1 : i % 2);
      end
      fin("byte_memory");
    end
    // Counts out of range, enabled terminal, test mode off
    for (int k = 0; k < 5; k++) begin
      term_dis_i <= (k == 3) ? 3'h6 : 3'h7;
      term_test_i <= (k == 4) ? 3'h6 : 3'h7;
      ex(2'h3, 32'h1);
      u_host.issue(mk(rops[k], 1'b1, 2'h0, 16'h0, rcnt[k]));
      fin("refusal");
    end
    term_dis_i <= 3'h7;
    term_test_i <= 3'h7;
    // Queue 2 with two-word cells; oversize and empty cells refused
    c = mk(tmb_pkg::TMB_OP_DEF_Q, 1'b0, 2'h0, 16'h0, 16'h0);
    c.q_idx = 4'h2;
    c.cell_sz = 16'h2;
    c.cells = 16'h4;
    u_host.issue(c);
    c.cell_sz = 16'h100;
    c.cells = 16'h80;
    ex(2'h3, 32'h1);
    u_host.issue(c);
    c.cell_sz = 16'h0;
    ex(2'h3, 32'h1);
    u_host.issue(c);
    fin("queue_define");
    link_q_i <= '{4'h2, 4'h0, 4'h0};
    link_en_i <= 3'h1;
    qwr(4);
    for (int j = 0; j < 2; j++) begin
      ex(2'h0, {4'h0, 2'h0, 10'h0, wq.pop_front()});
      ex(2'h0, {4'h0, 2'h0, 10'h1, wq.pop_front()});
      xmit();
      fin("queue_move");
    end
    xmit();
    fin("queue_empty");
    qwr(1);
    xmit();
    fin("partial_cell");
    qwr(1);
    c = mk(tmb_pkg::TMB_OP_CLR_Q, 1'b0, 2'h0, 16'h0, 16'h0);
    c.q_idx = 4'h2;
    u_host.issue(c);
    xmit();
    fin("clear_one");
    qwr(2);
    u_host.issue(mk(tmb_pkg::TMB_OP_CLR_ALL_Q, 1'b0, 2'h0, 16'h0, 16'h0));
    xmit();
    fin("clear_all");
    wrap_up();
  end
endmodule // tb_top
